// file: include/hpsc_defs.svh
// Purpose: Offsets, field positions and reset values of the slot registers
// Assumes: Byte offsets within configuration space
// Notes:   Definitions only
`ifndef HPSC_DEFS_SVH
`define HPSC_DEFS_SVH

// ****************************************************************
// Offsets
// ****************************************************************
`define HPSC_CAP_OFF      8'hD4
`define HPSC_CTL_OFF      8'hD8

// ****************************************************************
// Capability word fields
// ****************************************************************
`define HPSC_CAP_FLG_LSB  0
`define HPSC_CAP_FLG_MSB  6
`define HPSC_PLV_LSB      7
`define HPSC_PLV_MSB      14
`define HPSC_PLS_LSB      15
`define HPSC_PLS_MSB      16
`define HPSC_SNUM_LSB     19
`define HPSC_SNUM_MSB     31

// ****************************************************************
// Control word fields
// ****************************************************************
`define HPSC_EN_BTN_BIT   0
`define HPSC_EN_PWF_BIT   1
`define HPSC_EN_PDC_BIT   3
`define HPSC_EN_CMD_BIT   4

// ****************************************************************
// Reset values
// ****************************************************************
`define HPSC_CAP_FLG_RST  7'h5F
`define HPSC_PLV_RST      8'h19
`define HPSC_PLS_RST      2'h0
`define HPSC_SNUM_RST     13'h0000
`define HPSC_EN_RST       4'h0

`endif

// file: include/hpsc_pkg.sv
// Purpose: Types shared by the slot register block
// Assumes: Nothing
// Notes:   Constants live in hpsc_defs.svh
package hpsc_pkg;

	typedef struct packed {
		logic        req;
		logic        wr;
		logic [7:0]  addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} hpsc_cfg_req_t;

	typedef struct packed {
		logic        wr;
		logic        sel_ctl;
		logic [31:0] data;
	} hpsc_sb_t;

	typedef struct packed {
		logic [7:0] value;
		logic [1:0] scale;
	} hpsc_spl_t;

	typedef enum logic {
		HPSC_TX_IDLE,
		HPSC_TX_SEND
	} hpsc_tx_state_t;

endpackage

// file: core/hpsc_evt_gate.sv
// Purpose: Turns a newly set status flag into a request if enabled
// Assumes: Flag comes from logic on the same clock
// Notes:   One instance per slot event
`timescale 1ns/1ps

module hpsc_evt_gate (
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic flag_in,
	input  wire logic enable_in,
	output logic      pulse_out
);
	logic flag_q;
	logic rise;

	assign rise = flag_in & ~flag_q;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_in;
		end
	end

	// Request only on a new flag with its enable set
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pulse_out <= 1'b0;
		end else begin
			pulse_out <= rise & enable_in;
		end
	end

	AST_EVT_FIRE: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		rise && enable_in |=> pulse_out)
		else $error("Enabled new flag gave no request");
	AST_EVT_QUIET: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		!(rise && enable_in) |=> !pulse_out)
		else $error("Request without enabled new flag");

endmodule

// file: core/hpsc_msg_tx.sv
// Purpose: Holds a power limit message until the link takes it
// Assumes: Link side accepts on valid and ready high together
// Notes:   A retrigger while pending sends the newest payload
`timescale 1ns/1ps

module hpsc_msg_tx
	import hpsc_pkg::*;
(
	input  wire logic               clk_in,
	input  wire logic               rst_n_in,
	input  wire logic               send_in,
	input  hpsc_pkg::hpsc_spl_t     payload_in,
	input  wire logic               ready_in,
	output logic                    valid_out,
	output hpsc_pkg::hpsc_spl_t     msg_out
);
	import hpsc_pkg::*;

	hpsc_tx_state_t state;

	// ****************************************************************
	// Sender state
	// ****************************************************************
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= HPSC_TX_IDLE;
		end else begin
			unique case (state)
				HPSC_TX_IDLE: begin
					if (send_in) begin
						state <= HPSC_TX_SEND;
					end
				end
				HPSC_TX_SEND: begin
					if (ready_in && !send_in) begin
						state <= HPSC_TX_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			msg_out <= '0;
		end else if (send_in) begin
			msg_out <= payload_in;
		end
	end

	assign valid_out = (state == HPSC_TX_SEND);

	AST_MSG_HOLD: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		valid_out && !ready_in && !send_in
		|=> valid_out && $stable(msg_out))
		else $error("Pending message dropped or changed");

endmodule

// file: core/hpsc_slot_regs.sv
// Purpose: Slot capability and slot event enable registers of a port
// Assumes: Config and sideband requests come on the core clock
// Notes:   Registers exist only while the port strap says downstream
`timescale 1ns/1ps
`include "hpsc_defs.svh"

// Behaviour
// - Bit0 read-only attention button present, reset 1
// - Bit1 read-only power controller present, reset 1
// - Bit2 read-only retention latch sensor, reset 1
// - Bit3 read-only attention indicator present, reset 1
// - Bit4 read-only power indicator present, reset 1
// - Bit5 read-only surprise removal possible, reset 0
// - Bit6 read-only hot-plug capable, reset 1
// - Bits14:7 writable power limit value, reset 19h
// - Bits16:15 writable power limit scale, reset 0
// - Writing value or scale sends power message
// - Capability word exists on downstream ports only
// - Bits31:19 read-only slot number; 18:17 reserved
// - Sideband may replace every default
// - Control bit0 enables attention button requests
// - Control bit1 enables power fault requests
// - Control bit3 enables presence change requests
// - Control bit4 enables command completed requests
module hpsc_slot_regs
	import hpsc_pkg::*;
(
	input  wire logic               clk_in,
	input  wire logic               rst_n_in,
	input  wire logic               downstream_in,
	input  hpsc_pkg::hpsc_cfg_req_t cfg_in,
	output logic                    cfg_ack_out,
	output logic [31:0]             cfg_rdata_out,
	input  hpsc_pkg::hpsc_sb_t      sb_in,
	input  wire logic [3:0]         evt_flag_in,
	output logic [3:0]              evt_req_out,
	output logic                    hp_req_out,
	input  wire logic               spl_ready_in,
	output logic                    spl_valid_out,
	output hpsc_pkg::hpsc_spl_t     spl_msg_out
);
	import hpsc_pkg::*;

	// ****************************************************************
	// Storage
	// ****************************************************************
	logic [6:0]  cap_flags;
	logic [7:0]  plv;
	logic [1:0]  pls;
	logic [12:0] slot_num;
	logic [3:0]  evt_en;
	logic        dn_meta;
	logic        dn_sync;
	logic [31:0] cap_word;
	logic [31:0] ctl_word;
	logic [31:0] cap_merged;
	logic [31:0] ctl_merged;
	logic        hit_cap;
	logic        hit_ctl;
	logic        sw_cap_wr;
	logic        sw_ctl_wr;
	logic        sb_cap_wr;
	logic        sb_ctl_wr;
	logic        spl_touch;
	logic        send_spl;
	hpsc_spl_t   spl_payload;

	// Byte-enable merge of a write onto the current word
	function automatic logic [31:0] merge_be(
		input logic [31:0] old_w,
		input logic [31:0] new_w,
		input logic [3:0]  be
	);
		logic [31:0] res;
		res = old_w;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = new_w[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// ****************************************************************
	// Port direction strap
	// ****************************************************************
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dn_meta <= 1'b0;
			dn_sync <= 1'b0;
		end else begin
			dn_meta <= downstream_in;
			dn_sync <= dn_meta;
		end
	end

	// ****************************************************************
	// Decode
	// ****************************************************************
	assign hit_cap   = dn_sync && (cfg_in.addr == `HPSC_CAP_OFF);
	assign hit_ctl   = dn_sync && (cfg_in.addr == `HPSC_CTL_OFF);
	assign sw_cap_wr = cfg_in.req && cfg_in.wr && hit_cap;
	assign sw_ctl_wr = cfg_in.req && cfg_in.wr && hit_ctl;
	assign sb_cap_wr = sb_in.wr && !sb_in.sel_ctl;
	assign sb_ctl_wr = sb_in.wr && sb_in.sel_ctl;

	// Reserved bits 18:17 read as zero and ignore writes
	assign cap_word = {slot_num, 2'b00, pls, plv, cap_flags};
	assign ctl_word = {27'h0000000, evt_en[3], evt_en[2], 1'b0,
		evt_en[1], evt_en[0]};

	assign cap_merged = merge_be(cap_word, cfg_in.wdata, cfg_in.be);
	assign ctl_merged = merge_be(ctl_word, cfg_in.wdata, cfg_in.be);

	// Value spans bytes 0 and 1, scale spans bytes 1 and 2
	assign spl_touch = |cfg_in.be[2:0];
	assign send_spl  = sw_cap_wr && spl_touch;
	// Sideband wins a tie, so the message carries what the register keeps
	assign spl_payload.value = sb_cap_wr
		? sb_in.data[`HPSC_PLV_MSB:`HPSC_PLV_LSB]
		: cap_merged[`HPSC_PLV_MSB:`HPSC_PLV_LSB];
	assign spl_payload.scale = sb_cap_wr
		? sb_in.data[`HPSC_PLS_MSB:`HPSC_PLS_LSB]
		: cap_merged[`HPSC_PLS_MSB:`HPSC_PLS_LSB];

	// ****************************************************************
	// Read-only capability fields
	// ****************************************************************
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cap_flags <= `HPSC_CAP_FLG_RST;
			slot_num  <= `HPSC_SNUM_RST;
		end else if (sb_cap_wr) begin
			// Software cannot change these; sideband can
			cap_flags <= sb_in.data[`HPSC_CAP_FLG_MSB:`HPSC_CAP_FLG_LSB];
			slot_num  <= sb_in.data[`HPSC_SNUM_MSB:`HPSC_SNUM_LSB];
		end
	end

	// ****************************************************************
	// Power limit value and scale
	// ****************************************************************
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			plv <= `HPSC_PLV_RST;
			pls <= `HPSC_PLS_RST;
		end else if (sb_cap_wr) begin
			plv <= sb_in.data[`HPSC_PLV_MSB:`HPSC_PLV_LSB];
			pls <= sb_in.data[`HPSC_PLS_MSB:`HPSC_PLS_LSB];
		end else if (sw_cap_wr) begin
			plv <= cap_merged[`HPSC_PLV_MSB:`HPSC_PLV_LSB];
			pls <= cap_merged[`HPSC_PLS_MSB:`HPSC_PLS_LSB];
		end
	end

	// ****************************************************************
	// Event enables
	// ****************************************************************
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			evt_en <= `HPSC_EN_RST;
		end else if (sb_ctl_wr) begin
			evt_en <= {sb_in.data[`HPSC_EN_CMD_BIT], sb_in.data[`HPSC_EN_PDC_BIT],
				sb_in.data[`HPSC_EN_PWF_BIT], sb_in.data[`HPSC_EN_BTN_BIT]};
		end else if (sw_ctl_wr) begin
			evt_en[0] <= ctl_merged[`HPSC_EN_BTN_BIT];
			evt_en[1] <= ctl_merged[`HPSC_EN_PWF_BIT];
			evt_en[2] <= ctl_merged[`HPSC_EN_PDC_BIT];
			evt_en[3] <= ctl_merged[`HPSC_EN_CMD_BIT];
		end
	end

	// ****************************************************************
	// Config answer
	// ****************************************************************
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cfg_ack_out <= 1'b0;
		end else begin
			cfg_ack_out <= cfg_in.req;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cfg_rdata_out <= 32'h00000000;
		end else if (cfg_in.req) begin
			if (cfg_in.wr) begin
				cfg_rdata_out <= 32'h00000000;
			end else if (hit_cap) begin
				cfg_rdata_out <= cap_word;
			end else if (hit_ctl) begin
				cfg_rdata_out <= ctl_word;
			end else begin
				cfg_rdata_out <= 32'h00000000;
			end
		end
	end

	// ****************************************************************
	// Event gating
	// ****************************************************************
	for (genvar g = 0; g < 4; g++) begin : g_evt
		hpsc_evt_gate u_gate (
			.clk_in    (clk_in),
			.rst_n_in  (rst_n_in),
			.flag_in   (evt_flag_in[g]),
			.enable_in (evt_en[g] & dn_sync),
			.pulse_out (evt_req_out[g])
		);
	end

	assign hp_req_out = |evt_req_out;

	// ****************************************************************
	// Power limit message
	// ****************************************************************
	hpsc_msg_tx u_msg (
		.clk_in     (clk_in),
		.rst_n_in   (rst_n_in),
		.send_in    (send_spl),
		.payload_in (spl_payload),
		.ready_in   (spl_ready_in),
		.valid_out  (spl_valid_out),
		.msg_out    (spl_msg_out)
	);

	// ****************************************************************
	// Checks
	// ****************************************************************
	sequence hpsc_sw_cap_only;
		sw_cap_wr && !sb_in.wr;
	endsequence

	sequence hpsc_sw_ctl_only;
		sw_ctl_wr && !sb_in.wr && cfg_in.be[0];
	endsequence

	sequence hpsc_cap_rd;
		cfg_in.req && !cfg_in.wr && hit_cap;
	endsequence

	AST_CAP_RO: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		hpsc_sw_cap_only |=> $stable(cap_flags) && $stable(slot_num))
		else $error("Software changed a read-only field");

	AST_FLG_RST: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		$rose(rst_n_in) |-> cap_flags[3] && cap_flags[4] && !cap_flags[5])
		else $error("Capability flags wrong after reset");

	AST_PLV_WR: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		hpsc_sw_cap_only ##0 (cfg_in.be[1:0] == 2'h3)
		|=> plv == $past(cfg_in.wdata[14:7]))
		else $error("Power limit value not written");

	AST_PLS_WR: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		hpsc_sw_cap_only ##0 (cfg_in.be[2:1] == 2'h3)
		|=> pls == $past(cfg_in.wdata[16:15]))
		else $error("Power limit scale not written");

	AST_SPL_SEND: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		sw_cap_wr && spl_touch |=> spl_valid_out
		&& spl_msg_out.value == plv && spl_msg_out.scale == pls)
		else $error("Power limit write sent no message");

	AST_SPL_ONLY: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		!spl_valid_out && !send_spl |=> !spl_valid_out)
		else $error("Message raised without a software write");

	AST_UP_HIDDEN: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		!dn_sync && cfg_in.req |=> cfg_ack_out
		&& cfg_rdata_out == 32'h00000000)
		else $error("Slot registers visible on upstream port");

	AST_DN_QUIET: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		!dn_sync |=> !hp_req_out)
		else $error("Request raised on an upstream port");

	AST_RSVD_ZERO: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		cfg_ack_out |-> cfg_rdata_out[18:17] == 2'h0)
		else $error("Reserved bits read nonzero");

	AST_CAP_RD: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		hpsc_cap_rd |=> cfg_rdata_out[31:19] == $past(slot_num)
		&& cfg_rdata_out[6:0] == $past(cap_flags))
		else $error("Capability read lost a fixed field");

	AST_SB_OVR: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		sb_cap_wr |=> cap_word[16:0] == $past(sb_in.data[16:0])
		&& slot_num == $past(sb_in.data[31:19]))
		else $error("Sideband did not replace defaults");

	AST_SB_CTL: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		sb_ctl_wr |=> evt_en == {$past(sb_in.data[4]),
		$past(sb_in.data[3]), $past(sb_in.data[1]),
		$past(sb_in.data[0])})
		else $error("Sideband did not replace enables");

	AST_EN_WR: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		hpsc_sw_ctl_only |=> evt_en == {$past(cfg_in.wdata[4]),
		$past(cfg_in.wdata[3]), $past(cfg_in.wdata[1]),
		$past(cfg_in.wdata[0])})
		else $error("Event enables not written");

	AST_REQ_EN: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		hp_req_out |-> $past(|(evt_en & evt_flag_in)))
		else $error("Request without an enabled event");

endmodule

// file: dv/hpsc_link_model.sv
// Purpose: Downstream link partner that takes power limit messages
// Assumes: Message is offered as valid with a held payload
// Notes:   Stall sets how many cycles pass before ready rises
`timescale 1ns/1ps

module hpsc_link_model
	import hpsc_pkg::*;
(
	input  wire logic           clk_in,
	input  wire logic           rst_n_in,
	input  wire logic [3:0]     stall_in,
	input  wire logic           valid_in,
	input  hpsc_pkg::hpsc_spl_t msg_in,
	output logic                ready_out,
	output hpsc_pkg::hpsc_spl_t rx_msg_out,
	output logic [7:0]          rx_count_out
);
	import hpsc_pkg::*;

	logic [3:0] wait_cnt;

	// ****************************************************************
	// Acceptance
	// ****************************************************************
	// Ready only after the chosen stall, so slow takers are exercised
	assign ready_out = valid_in && (wait_cnt >= stall_in);

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wait_cnt <= 4'h0;
		end else if (!valid_in || ready_out) begin
			wait_cnt <= 4'h0;
		end else if (wait_cnt != 4'hF) begin
			wait_cnt <= wait_cnt + 4'h1;
		end
	end

	// Message taken on valid and ready together
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_msg_out   <= '0;
			rx_count_out <= 8'h00;
		end else if (valid_in && ready_out) begin
			rx_msg_out   <= msg_in;
			rx_count_out <= rx_count_out + 8'h01;
		end
	end
endmodule

// file: dv/hpsc_slot_regs_tb.sv
// Purpose: Self-checking bench for the slot register block
// Assumes: Registers reached through the config request port
// Notes:   Link partner lives in hpsc_link_model.sv
`timescale 1ns/1ps
`include "hpsc_defs.svh"

module hpsc_slot_regs_tb;
	import hpsc_pkg::*;

	localparam logic [31:0] CAP_RST = {`HPSC_SNUM_RST, 2'b00,
		`HPSC_PLS_RST, `HPSC_PLV_RST, `HPSC_CAP_FLG_RST};

	logic          clk_in;
	logic          rst_n_in;
	logic          downstream;
	hpsc_cfg_req_t cfg;
	hpsc_sb_t      sb;
	logic [3:0]    flags;
	logic [3:0]    stall;
	logic          ack;
	logic [31:0]   rdata;
	logic [3:0]    evt_req;
	logic          hp_req;
	logic          ready;
	logic          valid;
	hpsc_spl_t     msg;
	hpsc_spl_t     rx_msg;
	logic [7:0]    rx_cnt;
	int            err_total;
	int            check_count;
	logic [4:0]    en_tab [4];

	hpsc_slot_regs dut_u (
		.clk_in        (clk_in),
		.rst_n_in      (rst_n_in),
		.downstream_in (downstream),
		.cfg_in        (cfg),
		.cfg_ack_out   (ack),
		.cfg_rdata_out (rdata),
		.sb_in         (sb),
		.evt_flag_in   (flags),
		.evt_req_out   (evt_req),
		.hp_req_out    (hp_req),
		.spl_ready_in  (ready),
		.spl_valid_out (valid),
		.spl_msg_out   (msg)
	);

	hpsc_link_model link_u (
		.clk_in       (clk_in),
		.rst_n_in     (rst_n_in),
		.stall_in     (stall),
		.valid_in     (valid),
		.msg_in       (msg),
		.ready_out    (ready),
		.rx_msg_out   (rx_msg),
		.rx_count_out (rx_cnt)
	);

	// ****************************************************************
	// Clock, watchdog and verdict
	// ****************************************************************
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end

	initial begin
		#100000;
		err_total++;
		stop_test();
	end

	task automatic stop_test();
		$display("checks=%0d errors=%0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ****************************************************************
	// Compare and access tasks
	// ****************************************************************
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_msg(input hpsc_spl_t got, input hpsc_spl_t exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic put(input logic w, input logic [7:0] a,
		input logic [3:0] be, input logic [31:0] d);
		@(posedge clk_in);
		cfg <= '{req: 1'b1, wr: w, addr: a, be: be, wdata: d};
	endtask

	// Drops the request and waits a bounded time for the answer
	task automatic done();
		int n;
		@(posedge clk_in);
		cfg.req <= 1'b0;
		#1;
		n = 0;
		while (ack !== 1'b1 && n < 8) begin
			@(posedge clk_in);
			#1;
			n++;
		end
		chk_word({31'h0, ack}, 32'h1);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		put(1'b0, a, 4'hF, 32'h0);
		done();
		chk_word(rdata, exp);
	endtask

	task automatic wr(input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d);
		put(1'b1, a, be, d);
		done();
	endtask

	task automatic sbw(input logic sel, input logic [31:0] d);
		@(posedge clk_in);
		sb <= '{wr: 1'b1, sel_ctl: sel, data: d};
		@(posedge clk_in);
		sb.wr <= 1'b0;
	endtask

	// Span covers the slowest stall, so a second message would show
	task automatic msg_chk(input logic [7:0] n, input logic [7:0] v,
		input logic [1:0] s);
		repeat (12) @(posedge clk_in);
		#1;
		chk_word({24'h0, rx_cnt}, {24'h0, n});
		chk_msg(rx_msg, {v, s});
	endtask

	// Raises flags, collects requests and counts interrupt pulses
	task automatic evt(input logic [3:0] f, input logic [3:0] exp);
		logic [3:0] acc;
		int         hits;
		acc = 4'h0;
		hits = 0;
		@(posedge clk_in);
		flags <= f;
		repeat (4) begin
			@(posedge clk_in);
			#1;
			acc = acc | evt_req;
			if (hp_req === 1'b1) begin
				hits++;
			end
		end
		chk_word({28'h0, acc}, {28'h0, exp});
		chk_word(32'(hits), {31'h0, |exp});
		@(posedge clk_in);
		flags <= 4'h0;
		repeat (2) @(posedge clk_in);
	endtask

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		err_total = 0;
		check_count = 0;
		rst_n_in = 1'b0;
		downstream = 1'b1;
		cfg = '0;
		sb = '0;
		flags = 4'h0;
		stall = 4'h0;
		en_tab = '{5'h01, 5'h02, 5'h08, 5'h10};
		repeat (5) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		rd(`HPSC_CAP_OFF, CAP_RST);
		rd(`HPSC_CAP_OFF, CAP_RST);
		rd(`HPSC_CAP_OFF, CAP_RST);
		rd(`HPSC_CTL_OFF, 32'h0);
		wr(`HPSC_CAP_OFF, 4'hF, 32'hFFFF_FFFF);
		rd(`HPSC_CAP_OFF, 32'h0001_FFDF);
		msg_chk(8'h01, 8'hFF, 2'h3);
		wr(`HPSC_CAP_OFF, 4'h8, 32'h0);
		rd(`HPSC_CAP_OFF, 32'h0001_FFDF);
		msg_chk(8'h01, 8'hFF, 2'h3);
		stall <= 4'h6;
		put(1'b1, `HPSC_CAP_OFF, 4'hF, {15'h0, 2'h1, 8'h10, 7'h0});
		put(1'b1, `HPSC_CAP_OFF, 4'hF, {15'h0, 2'h2, 8'h22, 7'h0});
		done();
		msg_chk(8'h02, 8'h22, 2'h2);
		rd(`HPSC_CAP_OFF, {15'h0, 2'h2, 8'h22, 7'h5F});
		sbw(1'b0, 32'hFFFF_FFFF);
		rd(`HPSC_CAP_OFF, 32'hFFF9_FFFF);
		msg_chk(8'h02, 8'h22, 2'h2);
		wr(`HPSC_CAP_OFF, 4'h4, 32'h0);
		rd(`HPSC_CAP_OFF, 32'hFFF8_FFFF);
		msg_chk(8'h03, 8'hFF, 2'h1);
		sbw(1'b1, 32'hFFFF_FFFF);
		rd(`HPSC_CTL_OFF, 32'h0000_001B);
		for (int i = 0; i < 4; i++) begin
			wr(`HPSC_CTL_OFF, 4'hF, {27'h0, en_tab[i]});
			evt(4'hF, 4'h1 << i);
		end
		wr(`HPSC_CTL_OFF, 4'hF, 32'h0);
		evt(4'hF, 4'h0);
		wr(`HPSC_CTL_OFF, 4'hF, 32'h0000_001B);
		@(posedge clk_in);
		downstream <= 1'b0;
		repeat (3) @(posedge clk_in);
		rd(`HPSC_CAP_OFF, 32'h0);
		rd(`HPSC_CTL_OFF, 32'h0);
		evt(4'hF, 4'h0);
		stop_test();
	end
endmodule
